// ### inc/sar_adc_pkg.sv
// Functional notes
// - Every channel conversion yields twelve result bits.
// - One conversion lasts exactly 32 converter clocks.
// - Prescaler divides system clock by 2/4/8/16.
// - Four channels, separately enabled, own results.
// - Channels A and B held before converting.
// - Enabled channels converted one after another.
// - Sequence end raises the converter interrupt event.
// - Power bit seven powers converter, clear powers down.
// - Interrupt enable bit five gates completion request.
// - Go bit four starts sequence, self-clears when done.
// - Software go ignored during hardware-started sequence.
// - Left format: upper eight high, lower four low.
// - Right format: high nibble zero, low byte lower.
// - Channel select bits choose participating channels.
// - New result sets flag; low byte read clears.
// - Set flag blocks overwriting that channel's result.
package sar_adc_pkg;

	// ****************************************
	// Register indices and byte addresses
	// ****************************************
	localparam logic [7:0]  IDX_CFG   = 8'hA9;
	localparam logic [7:0]  IDX_CHAN  = 8'hB9;
	localparam logic [7:0]  IDX_A_LO  = 8'hBA;
	localparam logic [7:0]  IDX_A_HI  = 8'hBB;
	localparam logic [7:0]  IDX_B_LO  = 8'hBC;
	localparam logic [7:0]  IDX_B_HI  = 8'hBD;
	localparam logic [7:0]  IDX_C_LO  = 8'hBE;
	localparam logic [7:0]  IDX_C_HI  = 8'hBF;
	localparam logic [7:0]  IDX_D_LO  = 8'hAA;
	localparam logic [7:0]  IDX_D_HI  = 8'hAB;
	localparam logic [11:0] ADDR_CFG  = {2'b00, IDX_CFG, 2'b00};
	localparam logic [11:0] ADDR_CHAN = {2'b00, IDX_CHAN, 2'b00};
	localparam logic [11:0] ADDR_A_LO = {2'b00, IDX_A_LO, 2'b00};
	localparam logic [11:0] ADDR_A_HI = {2'b00, IDX_A_HI, 2'b00};
	localparam logic [11:0] ADDR_B_LO = {2'b00, IDX_B_LO, 2'b00};
	localparam logic [11:0] ADDR_B_HI = {2'b00, IDX_B_HI, 2'b00};
	localparam logic [11:0] ADDR_C_LO = {2'b00, IDX_C_LO, 2'b00};
	localparam logic [11:0] ADDR_C_HI = {2'b00, IDX_C_HI, 2'b00};
	localparam logic [11:0] ADDR_D_LO = {2'b00, IDX_D_LO, 2'b00};
	localparam logic [11:0] ADDR_D_HI = {2'b00, IDX_D_HI, 2'b00};

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int         POWER_BIT   = 7;
	localparam int         IRQ_EN_BIT  = 5;
	localparam int         GO_BIT      = 4;
	localparam int         JUSTIFY_BIT = 3;
	localparam int         DIV_HI_BIT  = 1;
	localparam int         DIV_LO_BIT  = 0;
	localparam logic [7:0] CFG_RESET   = 8'h00;
	localparam logic [3:0] CHAN_RESET  = 4'h0;

	// ****************************************
	// Conversion timing
	// ****************************************
	localparam int         RESULT_BITS  = 12;
	localparam int         NUM_CHANS    = 4;
	localparam logic [4:0] CONV_LAST    = 5'd31;
	localparam logic [4:0] SAMPLE_LAST  = 5'd19;
	localparam logic [4:0] DECIDE_FIRST = 5'd20;
	localparam logic [3:0] DIV_LAST_2   = 4'd1;
	localparam logic [3:0] DIV_LAST_4   = 4'd3;
	localparam logic [3:0] DIV_LAST_8   = 4'd7;
	localparam logic [3:0] DIV_LAST_16  = 4'd15;
	localparam logic [11:0] SAR_FIRST   = 12'h0_800;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_HOLD = 4'b0010,
		S_CONV = 4'b0100,
		S_DONE = 4'b1000
	} seq_state_e;

endpackage : sar_adc_pkg

// ### core/adc_clk_divider.sv
module adc_clk_divider
	import sar_adc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       ce,
	// Control
	input  wire logic       run,
	input  wire logic [1:0] divSel,
	// Converter clock
	output logic            tick,
	output logic            adcClk
);

	logic [3:0] cnt_q;
	logic [3:0] lim;
	logic       clk_q;

	// ****************************************
	// Divide ratio select
	// ****************************************
	always_comb begin
		case (divSel)
			2'b00:   lim = DIV_LAST_2;
			2'b01:   lim = DIV_LAST_4;
			2'b10:   lim = DIV_LAST_8;
			default: lim = DIV_LAST_16;
		endcase
	end

	assign tick   = run && ce && (cnt_q == lim);
	assign adcClk = clk_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 4'h0;
		end else if (ce) begin
			if (!run || cnt_q >= lim) begin
				cnt_q <= 4'h0;
			end else begin
				cnt_q <= cnt_q + 4'd1;
			end
		end
	end

	// High in the second half of each period, falling after the tick
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_q <= 1'b0;
		end else if (ce) begin
			clk_q <= run && (cnt_q >= (lim >> 1)) && (cnt_q != lim);
		end
	end

endmodule : adc_clk_divider

// ### core/adc_result_store.sv
module adc_result_store
	import sar_adc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	input  wire logic                   ce,
	// Write port
	input  wire logic                   wrEn,
	input  wire logic [1:0]             wrAddr,
	input  wire logic [RESULT_BITS-1:0] wrData,
	// Read port
	input  wire logic [1:0]             rdAddr,
	output logic      [RESULT_BITS-1:0] rdData
);

	logic [RESULT_BITS-1:0] mem_q [NUM_CHANS];
	logic [RESULT_BITS-1:0] rd_q;

	assign rdData = rd_q;

	// One word per channel
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_CHANS; i++) begin
				mem_q[i] <= '0;
			end
		end else if (ce && wrEn) begin
			mem_q[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_q <= '0;
		end else if (ce) begin
			rd_q <= mem_q[rdAddr];
		end
	end

endmodule : adc_result_store

// ### core/sar_adc_sequencer_control.sv
module sar_adc_sequencer_control
	import sar_adc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Trigger and event
	input  wire logic        hwTrigger,
	output logic             completionIrq,
	// Analog core
	input  wire logic        anaCmp,
	output logic             adcPowerOn,
	output logic             adcClk,
	output logic             holdA,
	output logic             holdB,
	output logic             sampleEn,
	output logic      [1:0]  chanSel,
	output logic      [11:0] dacCode
);

	// ****************************************
	// Decode helpers
	// ****************************************
	// {isResult, isHigh, channel}
	function automatic logic [3:0] resultSlot(input logic [11:0] a);
		case (a)
			ADDR_A_LO: resultSlot = 4'b1000;
			ADDR_A_HI: resultSlot = 4'b1100;
			ADDR_B_LO: resultSlot = 4'b1001;
			ADDR_B_HI: resultSlot = 4'b1101;
			ADDR_C_LO: resultSlot = 4'b1010;
			ADDR_C_HI: resultSlot = 4'b1110;
			ADDR_D_LO: resultSlot = 4'b1011;
			ADDR_D_HI: resultSlot = 4'b1111;
			default:   resultSlot = 4'b0000;
		endcase
	endfunction : resultSlot

	// {found, channel}: lowest enabled channel at or above start
	function automatic logic [2:0] firstFrom(input logic [3:0] en,
			input logic [2:0] start);
		firstFrom = 3'b000;
		for (int i = NUM_CHANS - 1; i >= 0; i--) begin
			if (en[i] && (i >= int'(start))) begin
				firstFrom = {1'b1, 2'(i)};
			end
		end
	endfunction : firstFrom

	// ****************************************
	// State
	// ****************************************
	seq_state_e  state_q;
	logic        powerOn_q;
	logic        irqEn_q;
	logic        go_q;
	logic        justify_q;
	logic [1:0]  divSel_q;
	logic [3:0]  chanEn_q;
	logic [3:0]  flag_q;
	logic [1:0]  chan_q;
	logic [4:0]  cnt_q;
	logic [11:0] sar_q;
	logic        irq_q;
	logic        wait_q;
	logic [31:0] prdata_q;
	logic        err_q;
	logic        cmpMeta_q;
	logic        cmpSync_q;
	logic [1:0]  rdSlot_q;

	logic        tick;
	logic        apbDone;
	logic        wrCfg;
	logic        wrChan;
	logic        idle;
	logic        hwStart;
	logic        swStart;
	logic        convEnd;
	logic        resultWr;
	logic [11:0] sarNext;
	logic [2:0]  first;
	logic [2:0]  next;
	logic [3:0]  slot;
	logic [3:0]  loRead;
	logic [11:0] memRd;
	logic [15:0] fmt;

	// ****************************************
	// Comparator synchroniser
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmpMeta_q <= 1'b0;
			cmpSync_q <= 1'b0;
		end else if (ce) begin
			cmpMeta_q <= anaCmp;
			cmpSync_q <= cmpMeta_q;
		end
	end

	adc_clk_divider u_div (
		.clk    (clk),
		.arst_n (arst_n),
		.ce     (ce),
		.run    (powerOn_q),
		.divSel (divSel_q),
		.tick   (tick),
		.adcClk (adcClk)
	);

	// ****************************************
	// APB access: two-cycle access phase
	// ****************************************
	assign pready  = psel && penable && wait_q;
	assign pslverr = pready && err_q;
	assign prdata  = prdata_q;
	assign apbDone = pready && ce;
	assign wrCfg   = apbDone && pwrite && !err_q && (paddr == ADDR_CFG);
	assign wrChan  = apbDone && pwrite && !err_q && (paddr == ADDR_CHAN);
	assign slot    = resultSlot(paddr);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_q <= 1'b0;
			err_q  <= 1'b0;
		end else if (ce) begin
			wait_q <= psel && penable && !wait_q;
			err_q  <= !(slot[3] || paddr == ADDR_CFG || paddr == ADDR_CHAN);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdSlot_q <= 2'b00;
		end else if (ce && psel && !penable) begin
			rdSlot_q <= slot[1:0];
		end
	end

	adc_result_store u_store (
		.clk    (clk),
		.arst_n (arst_n),
		.ce     (ce),
		.wrEn   (resultWr),
		.wrAddr (chan_q),
		.wrData (sarNext),
		.rdAddr (psel && !penable ? slot[1:0] : rdSlot_q),
		.rdData (memRd)
	);

	// Justified result, {high byte, low byte}
	assign fmt = justify_q ? {memRd, 4'h0} : {4'h0, memRd};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (ce && psel && penable && !wait_q) begin
			prdata_q <= 32'h0000_0000;
			if (!pwrite && paddr == ADDR_CFG) begin
				prdata_q[7:0] <= {powerOn_q, 1'b0, irqEn_q, go_q,
						justify_q, 1'b0, divSel_q};
			end else if (!pwrite && paddr == ADDR_CHAN) begin
				prdata_q[7:0] <= {chanEn_q[0], chanEn_q[1], chanEn_q[2],
						chanEn_q[3], flag_q[0], flag_q[1], flag_q[2],
						flag_q[3]};
			end else if (!pwrite && slot[3]) begin
				prdata_q[7:0] <= slot[2] ? fmt[15:8] : fmt[7:0];
			end
		end
	end

	// ****************************************
	// Configuration and channel select
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			powerOn_q <= CFG_RESET[POWER_BIT];
			irqEn_q   <= CFG_RESET[IRQ_EN_BIT];
			justify_q <= CFG_RESET[JUSTIFY_BIT];
			divSel_q  <= {CFG_RESET[DIV_HI_BIT], CFG_RESET[DIV_LO_BIT]};
		end else if (wrCfg) begin
			powerOn_q <= pwdata[POWER_BIT];
			irqEn_q   <= pwdata[IRQ_EN_BIT];
			justify_q <= pwdata[JUSTIFY_BIT];
			divSel_q  <= {pwdata[DIV_HI_BIT], pwdata[DIV_LO_BIT]};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chanEn_q <= CHAN_RESET;
		end else if (wrChan) begin
			chanEn_q <= {pwdata[4], pwdata[5], pwdata[6], pwdata[7]};
		end
	end

	// ****************************************
	// Start requests
	// ****************************************
	assign idle    = (state_q == S_IDLE);
	assign hwStart = ce && hwTrigger && powerOn_q && idle;
	assign swStart = wrCfg && pwdata[GO_BIT] && powerOn_q && idle
			&& !hwTrigger;

	// Set only from idle, cleared only at sequence end or abort
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			go_q <= CFG_RESET[GO_BIT];
		end else if (ce) begin
			if (swStart) begin
				go_q <= 1'b1;
			end else if (state_q == S_DONE || !powerOn_q) begin
				go_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Successive approximation
	// ****************************************
	always_comb begin
		logic [3:0] bitIdx;
		bitIdx  = 4'(CONV_LAST - cnt_q);
		sarNext = sar_q;
		if (cnt_q == SAMPLE_LAST) begin
			sarNext = SAR_FIRST;
		end else if (cnt_q >= DECIDE_FIRST) begin
			if (!cmpSync_q) begin
				sarNext[bitIdx] = 1'b0;
			end
			if (bitIdx != 4'd0) begin
				sarNext[bitIdx - 4'd1] = 1'b1;
			end
		end
	end

	assign convEnd  = tick && (state_q == S_CONV) && (cnt_q == CONV_LAST);
	assign resultWr = convEnd && !flag_q[chan_q];
	assign first    = firstFrom(chanEn_q, 3'd0);
	assign next     = firstFrom(chanEn_q, {1'b0, chan_q} + 3'd1);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sar_q <= 12'h0_000;
		end else if (ce && tick && state_q == S_CONV) begin
			sar_q <= sarNext;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			chan_q  <= 2'b00;
			cnt_q   <= 5'd0;
		end else if (ce) begin
			if (!powerOn_q) begin
				state_q <= S_IDLE;
			end else begin
				case (state_q)
					S_IDLE: begin
						if (hwStart || swStart) begin
							state_q <= S_HOLD;
						end
					end
					S_HOLD: begin
						if (tick) begin
							cnt_q <= 5'd0;
							chan_q <= first[1:0];
							state_q <= first[2] ? S_CONV : S_DONE;
						end
					end
					S_CONV: begin
						if (convEnd) begin
							cnt_q <= 5'd0;
							chan_q <= next[1:0];
							state_q <= next[2] ? S_CONV : S_DONE;
						end else if (tick) begin
							cnt_q <= cnt_q + 5'd1;
						end
					end
					default: begin // DONE lasts one cycle
						state_q <= S_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Completion flags: set wins over clear
	// ****************************************
	assign loRead = (apbDone && !pwrite && slot[3] && !slot[2])
			? (4'b0001 << slot[1:0]) : 4'b0000;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= 4'h0;
		end else if (ce) begin
			for (int i = 0; i < NUM_CHANS; i++) begin
				if (resultWr && chan_q == 2'(i)) begin
					flag_q[i] <= 1'b1;
				end else if (loRead[i]) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= (state_q == S_DONE) && powerOn_q && irqEn_q;
		end
	end

	// ****************************************
	// Analog core controls
	// ****************************************
	assign completionIrq = irq_q;
	assign adcPowerOn    = powerOn_q;
	assign holdA         = !idle;
	assign holdB         = !idle;
	assign sampleEn      = (state_q == S_CONV) && (cnt_q <= SAMPLE_LAST);
	assign chanSel       = chan_q;
	assign dacCode       = sar_q;
endmodule : sar_adc_sequencer_control

// ### sim/adc_analog_model.sv
module adc_analog_model
	import sar_adc_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// Converter controls
	input  wire logic        adcPowerOn,
	input  wire logic        holdA,
	input  wire logic        holdB,
	input  wire logic [1:0]  chanSel,
	input  wire logic [11:0] dacCode,
	// Channel input levels
	input  wire logic [11:0] vin [NUM_CHANS],
	// Comparator
	output logic             anaCmp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] heldA;
	logic [11:0] heldB;
	logic [11:0] level;
	logic        junk = 1'b0;
	// ******************************
	// Track/hold stages and comparator
	// ******************************
	always_ff @(posedge clk) begin
		if (!holdA) heldA <= vin[0];
		if (!holdB) heldB <= vin[1];
		junk <= ~junk;
	end
	assign level = (chanSel == 2'd0) ? heldA :
		(chanSel == 2'd1) ? heldB : vin[chanSel];
	// Powered down: output carries no decision
	assign anaCmp = adcPowerOn ? (level >= dacCode) : junk;
endmodule : adc_analog_model

// ### sim/sar_adc_sequencer_control_monitor.sv
module sar_adc_sequencer_control_monitor
	import sar_adc_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// APB
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	// Converter
	input wire logic       completionIrq,
	input wire logic       adcPowerOn,
	input wire logic       adcClk,
	input wire logic       holdA,
	input wire logic       holdB,
	input wire logic       sampleEn,
	input wire logic [1:0] chanSel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] tickCnt_q;
	logic       clkPrev_q;
	logic       smpPrev_q;
	logic       inSeq_q;
	logic [1:0] lastChan_q;
	wire        clkRise = adcClk && !clkPrev_q;
	wire        convStart = sampleEn && !smpPrev_q;
	// ******************************
	// Converter clocks per conversion
	// ******************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clkPrev_q <= 1'b0;
			smpPrev_q <= 1'b0;
			tickCnt_q <= '0;
			inSeq_q <= 1'b0;
			lastChan_q <= '0;
		end else begin
			clkPrev_q <= adcClk;
			smpPrev_q <= sampleEn;
			if (convStart) begin
				tickCnt_q <= {5'd0, clkRise};
				inSeq_q <= 1'b1;
				lastChan_q <= chanSel;
			end else begin
				tickCnt_q <= tickCnt_q + {5'd0, clkRise};
				inSeq_q <= inSeq_q && holdA;
			end
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_oneWait;
		!pready ##1 pready;
	endsequence
	sequence s_nextConv;
		convStart && inSeq_q;
	endsequence
	AST_APB_WAIT: assert property (psel && $rose(penable) |-> s_oneWait)
		else $error("apb wait state wrong");
	AST_CONV_LEN: assert property (s_nextConv |-> tickCnt_q == 6'd32)
		else $error("conversion length wrong");
	AST_CHAN_ORDER: assert property (s_nextConv |-> chanSel > lastChan_q)
		else $error("channel order wrong");
	AST_HOLD_PAIR: assert property (holdA == holdB)
		else $error("holds differ");
	AST_SAMPLE_HELD: assert property (sampleEn |-> holdA && adcPowerOn)
		else $error("sampling without hold");
	AST_CLK_OFF: assert property (!adcPowerOn ##1 !adcPowerOn |-> !adcClk)
		else $error("clock while powered down");
	AST_IRQ_PULSE: assert property (completionIrq |=> !completionIrq)
		else $error("irq longer than a cycle");
	AST_IRQ_END: assert property ($rose(completionIrq) |-> !sampleEn &&
		($past(holdA) || $past(holdA, 2)))
		else $error("irq not at sequence end");
endmodule : sar_adc_sequencer_control_monitor

bind sar_adc_sequencer_control sar_adc_sequencer_control_monitor u_monitor (
	.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pready(pready), .completionIrq(completionIrq), .adcPowerOn(adcPowerOn),
	.adcClk(adcClk), .holdA(holdA), .holdB(holdB), .sampleEn(sampleEn),
	.chanSel(chanSel)
);

// ### sim/sar_adc_sequencer_control_tb_top.sv
module sar_adc_sequencer_control_tb_top
	import sar_adc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] HI_ADDR [NUM_CHANS] =
		'{ADDR_A_HI, ADDR_B_HI, ADDR_C_HI, ADDR_D_HI};
	localparam logic [11:0] LO_ADDR [NUM_CHANS] =
		'{ADDR_A_LO, ADDR_B_LO, ADDR_C_LO, ADDR_D_LO};
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        hwTrigger = 1'b0;
	logic        ce = 1'b1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        completionIrq;
	logic        anaCmp;
	logic        adcPowerOn;
	logic        holdA;
	logic        holdB;
	logic [1:0]  chanSel;
	logic [11:0] dacCode;
	logic [11:0] vin [NUM_CHANS] = '{12'h5A3, 12'h7E1, 12'hFFF, 12'h001};
	int          nErrors = 0;
	int          checkCount = 0;
	logic        irqSeen;
	always #4 clk = ~clk;
	sar_adc_sequencer_control u_dut (
		.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hwTrigger(hwTrigger), .completionIrq(completionIrq),
		.anaCmp(anaCmp), .adcPowerOn(adcPowerOn), .adcClk(), .holdA(holdA),
		.holdB(holdB), .sampleEn(), .chanSel(chanSel), .dacCode(dacCode)
	);
	adc_analog_model u_model (
		.clk(clk), .adcPowerOn(adcPowerOn), .holdA(holdA), .holdB(holdB),
		.chanSel(chanSel), .dacCode(dacCode), .vin(vin), .anaCmp(anaCmp)
	);
	// ******************************
	// Bus and check helpers
	// ******************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) nErrors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [7:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 8'h00, q, e);
		chk(q, {24'h00_0000, x});
	endtask : rdc
	task automatic rd_res(input int c, input logic l, input logic [11:0] v);
		rdc(HI_ADDR[c], l ? v[11:4] : {4'h0, v[11:8]});
		rdc(LO_ADDR[c], l ? {v[3:0], 4'h0} : v[7:0]);
	endtask : rd_res
	task automatic wait_seq();
		int n;
		irqSeen = 1'b0;
		repeat (3) @(posedge clk);
		for (n = 0; n < 4000 && holdA !== 1'b0; n++) begin
			@(posedge clk);
			irqSeen |= completionIrq;
		end
		repeat (4) begin
			@(posedge clk);
			irqSeen |= completionIrq;
		end
		if (n >= 4000) nErrors++;
	endtask : wait_seq
	// ******************************
	// Scenarios
	// ******************************
	task automatic t_regs();
		logic [31:0] q;
		logic        e;
		rdc(ADDR_CFG, CFG_RESET);
		rdc(ADDR_CHAN, 8'h00);
		apb(1'b0, 12'h000, 8'h00, q, e);
		chk(q, 32'h0);
		chk(32'(e), 32'h1);
		wr(ADDR_CFG, 8'hFF);
		rdc(ADDR_CFG, 8'hAB);
		chk(32'(adcPowerOn), 32'h1);
		wr(ADDR_CFG, 8'h00);
		@(posedge clk);
		chk(32'(adcPowerOn), 32'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_seq();
		logic [11:0] heldA;
		heldA = vin[0];
		wr(ADDR_CHAN, 8'hB0);
		wr(ADDR_CFG, 8'h83);
		repeat (2500) @(posedge clk);
		wr(ADDR_CFG, 8'hB3);
		rdc(ADDR_CFG, 8'hB3);
		chk(32'(holdA), 32'h1);
		vin[0] <= 12'h111;
		wait_seq();
		chk(32'(irqSeen), 32'h1);
		rdc(ADDR_CFG, 8'hA3);
		rdc(ADDR_CHAN, 8'hBB);
		rd_res(0, 1'b0, heldA);
		rd_res(2, 1'b0, vin[2]);
		rd_res(3, 1'b0, vin[3]);
		rdc(ADDR_CHAN, 8'hB0);
		$display("t_seq done");
	endtask : t_seq
	task automatic t_block();
		wr(ADDR_CHAN, 8'h80);
		vin[0] <= 12'hC35;
		wr(ADDR_CFG, 8'h9B);
		wait_seq();
		vin[0] <= 12'h2B7;
		wr(ADDR_CFG, 8'h9B);
		wait_seq();
		rd_res(0, 1'b1, 12'hC35);
		wr(ADDR_CFG, 8'h9B);
		wait_seq();
		rd_res(0, 1'b1, 12'h2B7);
		$display("t_block done");
	endtask : t_block
	task automatic t_hw();
		wr(ADDR_CHAN, 8'h40);
		wr(ADDR_CFG, 8'h83);
		@(posedge clk);
		ce <= 1'b0;
		hwTrigger <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'(holdA), 32'h0);
		ce <= 1'b1;
		@(posedge clk);
		hwTrigger <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(holdA), 32'h1);
		wr(ADDR_CFG, 8'h93);
		rdc(ADDR_CFG, 8'h83);
		wait_seq();
		chk(32'(irqSeen), 32'h0);
		rd_res(1, 1'b0, vin[1]);
		rdc(ADDR_CHAN, 8'h40);
		$display("t_hw done");
	endtask : t_hw
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_seq();
		t_block();
		t_hw();
		wr(ADDR_CFG, 8'h00);
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk);
		nErrors++;
		wrap_up();
	end
endmodule : sar_adc_sequencer_control_tb_top
